/* File: core/mss_defs.svh */
// Purpose: timing counts, setting ranges and defaults of the start sequencer
// Assumes: settings are sampled once, at the start command
// Notes:   time base is one tick every 0.1 s
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

// ==========================================================================
// time base
`define MSS_CLK_PERIOD_NS  10
`define MSS_TICK_TIME_NS   100000000
`define MSS_TICK_CYCLES    (`MSS_TICK_TIME_NS / `MSS_CLK_PERIOD_NS)
`define MSS_TENTHS_PER_SEC 14'd10
`define MSS_SETTLE_TICKS   4'd3

// ==========================================================================
// up-to-speed time, whole seconds; full-speed current threshold, percent
`define MSS_UTS_MIN        10'd1
`define MSS_UTS_MAX        10'd900
`define MSS_UTS_DEF        10'd20
`define MSS_UTS_PCT        175

// ==========================================================================
// ramp levels, percent; maximum ramp time, seconds
`define MSS_INIT_MIN       10'd1
`define MSS_INIT_MAX       10'd100
`define MSS_INIT_DEF       10'd25
`define MSS_END_MIN        10'd10
`define MSS_END_MAX        10'd325
`define MSS_END_DEF        10'd105
`define MSS_FULL_VOLT      10'd100
`define MSS_ICUR_MIN       10'd50
`define MSS_ICUR_MAX       10'd600
`define MSS_ICUR_DEF       10'd100
`define MSS_MCUR_MIN       10'd100
`define MSS_MCUR_MAX       10'd800
`define MSS_MCUR_DEF       10'd600
`define MSS_RAMP_MAX       10'd300

// ==========================================================================
// boost (kick) current and duration
`define MSS_KICK_OFF       10'd0
`define MSS_KICK_MIN       10'd100
`define MSS_KICK_MAX       10'd800
`define MSS_KTIME_MIN      10'd1
`define MSS_KTIME_MAX      10'd100
`define MSS_KTIME_DEF      10'd10

// ==========================================================================
// fault reporting
`define MSS_FAULT_UTS      8'h01
`define MSS_FAULT_NONE     8'h00

`endif

/* File: core/mss_pkg.sv */
// Purpose: shared types of the motor start sequencer
// Assumes: nothing
// Notes:   one-hot state codes are written out
package mss_pkg;

    typedef enum logic [1:0] {
        PROF_VOLT  = 2'h0,
        PROF_CURR  = 2'h1,
        PROF_TORQ  = 2'h2,
        PROF_POWER = 2'h3
    } mss_profile_e;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_KICK  = 6'h02,
        ST_RAMP  = 6'h04,
        ST_HOLD  = 6'h08,
        ST_RUN   = 6'h10,
        ST_FAULT = 6'h20
    } mss_state_e;

    // reference handed to the power-stage control loop
    typedef struct packed {
        mss_profile_e kind;
        logic [9:0]   level;
    } mss_ref_s;

    // settings captured at the start command
    typedef struct packed {
        logic [9:0]   uts_s;
        mss_profile_e prof;
        logic [9:0]   init_lvl;
        logic [9:0]   end_lvl;
        logic [9:0]   max_cur;
        logic [9:0]   kick_lvl;
        logic [6:0]   kick_t;
        logic [8:0]   ramp_s;
        logic         wye_delta;
    } mss_cfg_s;

endpackage

/* File: core/mss_tick_gen.sv */
// Purpose: 0.1 s time base for the start sequencer timers
// Assumes: i_run rises together with the start of a sequence
// Notes:   restarts from zero whenever i_run is low, so ticks align to start
`timescale 1ns/1ps
`include "mss_defs.svh"

module mss_tick_gen #(
    parameter int unsigned TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input  wire logic i_mclk,
    input  wire logic i_reset,
    input  wire logic i_run,
    output logic      o_tick
);

    logic [31:0] cnt_q;

    // ======================================================================
    // cycle counter
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_run) begin
            cnt_q <= 32'h0;
        end else if (cnt_q >= TICK_CYCLES - 1) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // ======================================================================
    // tick pulse, one cycle wide
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_run) begin
            o_tick <= 1'b0;
        end else begin
            o_tick <= (cnt_q >= TICK_CYCLES - 1);
        end
    end

endmodule

/* File: core/mss_motor_start_sequencer.sv */
// Purpose: start sequencing of a thyristor motor starter: boost, ramp,
//          up-to-speed supervision, stall fault, wye-delta transfer
// Assumes: all inputs come from logic on i_mclk; current readings in
//          the same unit as the rated load current
// Notes:   timers run in tenths of a second
// Functional notes
// - accel time limit is 1..900 whole seconds, default 20
// - timer expiry without full speed flags a stalled motor
// - full speed needs ramp expired and current settled below 175 percent
// - stall declares the up-to-speed fault, code 01
// - time limit never self-adjusts; ramp longer than it always faults
// - voltage profile applies full voltage at timer expiry
// - wye-delta topology transfers to delta at timer expiry if not done
// - four profiles: voltage, current, torque, power; current is default
// - ramp start level is 1..100 percent, default 25
// - voltage profile starts its ramp at the start level
// - torque or power profile starts at the start level
// - current profile ignores start level, uses initial current
// - ramp end level is 10..325 percent, default 105
// - voltage profile ignores end level and ends at 100 percent
// - torque profile reaches the end level when ramp time ends
// - power profile reaches the end level when ramp time ends
// - boost current is off or 100..800 percent, default off
// - boost is applied at start, before any ramp
// - boost lasts 0.1..10.0 s, default 1.0 s
// - ramp moves from initial to maximum over 0..300 seconds
// - after ramp expiry hold maximum current until speed, expiry, trip; code keeps it through run until stop, voltage profile holds 100 percent
`timescale 1ns/1ps
`include "mss_defs.svh"

module mss_motor_start_sequencer #(
    parameter int unsigned TICK_CYCLES = `MSS_TICK_CYCLES
) (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic       i_start_cmd,
    input  wire logic       i_overload_trip,
    input  wire logic [15:0] i_motor_current,
    input  wire logic [15:0] i_rated_load_current,
    input  wire logic [9:0] i_accel_time_limit_param,
    input  wire logic [1:0] i_ramp_profile_select_param,
    input  wire logic [9:0] i_ramp_start_level_param,
    input  wire logic [9:0] i_ramp_end_level_param,
    input  wire logic [9:0] i_init_current_param,
    input  wire logic [9:0] i_max_current_param,
    input  wire logic [8:0] i_ramp_time_param,
    input  wire logic [9:0] i_boost_current_level_param,
    input  wire logic [6:0] i_boost_duration_param,
    input  wire logic       i_starter_topology_param,
    output mss_pkg::mss_ref_s o_ref,
    output logic            o_starting,
    output logic            o_boosting,
    output logic            o_full_voltage,
    output logic            o_delta_run,
    output logic            o_full_speed_reached,
    output logic            o_fault,
    output logic [7:0]      o_fault_code
);

    // ======================================================================
    // setting sanitiser: out-of-range values fall back to the default
    function automatic logic [9:0] pick(input logic [9:0] v,
                                        input logic [9:0] lo,
                                        input logic [9:0] hi,
                                        input logic [9:0] dflt);
        return (v < lo || v > hi) ? dflt : v;
    endfunction

    mss_pkg::mss_state_e state_q;
    mss_pkg::mss_state_e state_d;
    mss_pkg::mss_cfg_s   cfg_q;
    mss_pkg::mss_cfg_s   cfg_d;
    mss_pkg::mss_cfg_s   cfg_use;
    mss_pkg::mss_profile_e prof_in;

    logic        start_q;
    logic        start_rise;
    logic        busy;
    logic        tick;
    logic [13:0] uts_cnt_q;
    logic [13:0] uts_lim;
    logic        uts_exp;
    logic [6:0]  kick_cnt_q;
    logic [11:0] ramp_cnt_q;
    logic [11:0] ramp_lim;
    logic        ramp_done_q;
    logic [9:0]  level_q;
    logic [12:0] acc_q;
    logic [9:0]  diff;
    logic        step;
    logic [3:0]  settle_q;
    logic        below;
    logic        up_to_speed;
    logic [9:0]  kick_in;
    logic [9:0]  ramp_in;
    mss_pkg::mss_ref_s ref_d;

    // ======================================================================
    // start command and time base
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            start_q <= 1'b0;
        end else begin
            start_q <= i_start_cmd;
        end
    end

    assign start_rise = i_start_cmd && !start_q;
    assign busy = state_q inside {mss_pkg::ST_KICK, mss_pkg::ST_RAMP, mss_pkg::ST_HOLD};

    mss_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .i_mclk  (i_mclk),
        .i_reset (i_reset),
        .i_run   (busy),
        .o_tick  (tick)
    );

    // ======================================================================
    // settings captured at start
    assign prof_in = mss_pkg::mss_profile_e'(i_ramp_profile_select_param);
    assign kick_in = i_boost_current_level_param;
    assign ramp_in = {1'b0, i_ramp_time_param};

    always_comb begin
        cfg_d = cfg_q;
        cfg_d.uts_s = pick(i_accel_time_limit_param, `MSS_UTS_MIN,
                           `MSS_UTS_MAX, `MSS_UTS_DEF);
        cfg_d.prof = prof_in;
        cfg_d.max_cur = pick(i_max_current_param, `MSS_MCUR_MIN,
                             `MSS_MCUR_MAX, `MSS_MCUR_DEF);
        case (prof_in)
            mss_pkg::PROF_CURR: begin
                cfg_d.init_lvl = pick(i_init_current_param, `MSS_ICUR_MIN,
                                      `MSS_ICUR_MAX, `MSS_ICUR_DEF);
                cfg_d.end_lvl = cfg_d.max_cur;
            end
            mss_pkg::PROF_VOLT: begin
                cfg_d.init_lvl = pick(i_ramp_start_level_param, `MSS_INIT_MIN,
                                      `MSS_INIT_MAX, `MSS_INIT_DEF);
                cfg_d.end_lvl = `MSS_FULL_VOLT;
            end
            default: begin
                cfg_d.init_lvl = pick(i_ramp_start_level_param, `MSS_INIT_MIN,
                                      `MSS_INIT_MAX, `MSS_INIT_DEF);
                cfg_d.end_lvl = pick(i_ramp_end_level_param, `MSS_END_MIN,
                                     `MSS_END_MAX, `MSS_END_DEF);
            end
        endcase
        cfg_d.kick_lvl = pick(kick_in, `MSS_KICK_MIN, `MSS_KICK_MAX,
                              `MSS_KICK_OFF);
        cfg_d.kick_t = 7'(pick({3'h0, i_boost_duration_param}, `MSS_KTIME_MIN,
                               `MSS_KTIME_MAX, `MSS_KTIME_DEF));
        cfg_d.ramp_s = 9'(pick(ramp_in, 10'd0, `MSS_RAMP_MAX, 10'd0));
        cfg_d.wye_delta = i_starter_topology_param;
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cfg_q <= '0;
            cfg_q.prof <= mss_pkg::PROF_CURR;
        end else if (state_q == mss_pkg::ST_IDLE && start_rise) begin
            cfg_q <= cfg_d;
        end
    end

    // ======================================================================
    // accel time limit, counted from the start command
    assign uts_lim = 14'(cfg_q.uts_s) * `MSS_TENTHS_PER_SEC;
    assign uts_exp = busy && tick && (uts_cnt_q >= uts_lim - 14'h1);

    always_ff @(posedge i_mclk) begin
        if (i_reset || !busy) begin
            uts_cnt_q <= 14'h0;
        end else if (tick) begin
            uts_cnt_q <= uts_cnt_q + 14'h1;
        end
    end

    // ======================================================================
    // boost duration
    always_ff @(posedge i_mclk) begin
        if (i_reset || state_q != mss_pkg::ST_KICK) begin
            kick_cnt_q <= 7'h0;
        end else if (tick) begin
            kick_cnt_q <= kick_cnt_q + 7'h1;
        end
    end

    // ======================================================================
    // ramp generator: an accumulator spreads the level steps evenly; the
    // divide is done one step per clock, far faster than the tick rate
    assign ramp_lim = 12'(cfg_q.ramp_s) * 12'(`MSS_TENTHS_PER_SEC);
    assign diff = (cfg_q.end_lvl > cfg_q.init_lvl) ? cfg_q.end_lvl - cfg_q.init_lvl
                                                  : 10'h0;
    assign step = (state_q == mss_pkg::ST_RAMP) && (acc_q >= {1'b0, ramp_lim})
               && (level_q < cfg_q.end_lvl) && (ramp_lim != 12'h0);

    always_ff @(posedge i_mclk) begin
        if (i_reset || state_q != mss_pkg::ST_RAMP) begin
            ramp_cnt_q <= 12'h0;
            acc_q <= 13'h0;
        end else begin
            if (tick) begin
                ramp_cnt_q <= ramp_cnt_q + 12'h1;
            end
            acc_q <= acc_q + (tick ? {3'h0, diff} : 13'h0)
                   - (step ? {1'b0, ramp_lim} : 13'h0);
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset || state_q == mss_pkg::ST_IDLE) begin
            ramp_done_q <= 1'b0;
        end else if (state_q == mss_pkg::ST_RAMP
                     && (ramp_lim == 12'h0 || (tick && ramp_cnt_q >= ramp_lim - 12'h1))) begin
            ramp_done_q <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            level_q <= 10'h0;
        end else if (state_q == mss_pkg::ST_IDLE) begin
            level_q <= cfg_d.init_lvl;
        end else if (state_q != mss_pkg::ST_RAMP) begin
            level_q <= level_q;
        end else if (ramp_done_q || ramp_lim == 12'h0) begin
            level_q <= cfg_q.end_lvl;
        end else if (step) begin
            level_q <= level_q + 10'h1;
        end
    end

    // ======================================================================
    // full speed detection: current must stay low for a few ticks
    assign below = (24'(i_motor_current) * 24'd100)
                 < (24'(i_rated_load_current) * 24'(`MSS_UTS_PCT));

    always_ff @(posedge i_mclk) begin
        if (i_reset || !busy || !below) begin
            settle_q <= 4'h0;
        end else if (tick && settle_q < `MSS_SETTLE_TICKS) begin
            settle_q <= settle_q + 4'h1;
        end
    end

    assign up_to_speed = ramp_done_q && below && (settle_q >= `MSS_SETTLE_TICKS);

    // ======================================================================
    // sequence control; stop or trip beats full speed beats expiry
    always_comb begin
        state_d = state_q;
        case (state_q)
            mss_pkg::ST_IDLE: begin
                if (start_rise) begin
                    state_d = (cfg_d.kick_lvl != `MSS_KICK_OFF) ? mss_pkg::ST_KICK
                                                               : mss_pkg::ST_RAMP;
                end
            end
            mss_pkg::ST_KICK, mss_pkg::ST_RAMP, mss_pkg::ST_HOLD: begin
                if (state_q == mss_pkg::ST_KICK && tick
                    && kick_cnt_q >= cfg_q.kick_t - 7'h1) begin
                    state_d = mss_pkg::ST_RAMP;
                end
                if (state_q == mss_pkg::ST_RAMP && ramp_done_q) begin
                    state_d = mss_pkg::ST_HOLD;
                end
                if (uts_exp) begin
                    state_d = mss_pkg::ST_FAULT;
                end
                if (up_to_speed) begin
                    state_d = mss_pkg::ST_RUN;
                end
                if (!i_start_cmd || i_overload_trip) begin
                    state_d = mss_pkg::ST_IDLE;
                end
            end
            mss_pkg::ST_RUN, mss_pkg::ST_FAULT: begin
                if (!i_start_cmd) begin
                    state_d = mss_pkg::ST_IDLE;
                end
            end
            default: state_d = mss_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_q <= mss_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ======================================================================
    // reference to the control loop
    assign cfg_use = (state_q == mss_pkg::ST_IDLE) ? cfg_d : cfg_q; // capture cycle too

    always_comb begin
        ref_d.kind = cfg_use.prof;
        ref_d.level = 10'h0;
        case (state_d)
            mss_pkg::ST_KICK: begin
                ref_d.kind = mss_pkg::PROF_CURR;
                ref_d.level = cfg_use.kick_lvl;
            end
            mss_pkg::ST_RAMP: begin
                ref_d.level = level_q;
            end
            mss_pkg::ST_HOLD, mss_pkg::ST_RUN: begin
                if (cfg_use.prof == mss_pkg::PROF_VOLT) begin
                    ref_d.level = `MSS_FULL_VOLT;
                end else begin
                    ref_d.kind = mss_pkg::PROF_CURR;
                    ref_d.level = cfg_use.max_cur;
                end
            end
            default: ref_d.level = 10'h0;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_ref <= '0;
            o_starting <= 1'b0;
            o_boosting <= 1'b0;
        end else begin
            o_ref <= ref_d;
            o_starting <= state_d inside {mss_pkg::ST_KICK, mss_pkg::ST_RAMP, mss_pkg::ST_HOLD};
            o_boosting <= (state_d == mss_pkg::ST_KICK);
        end
    end

    // ======================================================================
    // expiry actions: full voltage at expiry, delta transfer at expiry or full speed; both stay until stop
    always_ff @(posedge i_mclk) begin
        if (i_reset || state_d == mss_pkg::ST_IDLE) begin
            o_full_voltage <= 1'b0;
        end else if (uts_exp && cfg_q.prof == mss_pkg::PROF_VOLT) begin
            o_full_voltage <= 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset || state_d == mss_pkg::ST_IDLE) begin
            o_delta_run <= 1'b0;
        end else if (cfg_q.wye_delta && (uts_exp || up_to_speed)) begin
            o_delta_run <= 1'b1;
        end
    end

    // ======================================================================
    // status and fault report
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_full_speed_reached <= 1'b0;
            o_fault <= 1'b0;
            o_fault_code <= `MSS_FAULT_NONE;
        end else begin
            o_full_speed_reached <= (state_d == mss_pkg::ST_RUN);
            o_fault <= (state_d == mss_pkg::ST_FAULT);
            o_fault_code <= (state_d == mss_pkg::ST_FAULT) ? `MSS_FAULT_UTS : `MSS_FAULT_NONE;
        end
    end

endmodule

/* File: testbench/mss_seq_properties.sv */
// Purpose: port-level checks of the start sequencer
// Assumes: settings held stable for the whole of a start
// Notes:   timer bounds allow three cycles of pipeline slack
`timescale 1ns/1ps

module mss_seq_properties #(
    parameter int unsigned TICK_CYCLES = 10
) (
    input wire logic              i_mclk,
    input wire logic              i_reset,
    input wire logic              i_start_cmd,
    input wire logic [15:0]       i_motor_current,
    input wire logic [15:0]       i_rated_load_current,
    input wire logic [9:0]        i_accel_time_limit_param,
    input wire logic [1:0]        i_ramp_profile_select_param,
    input wire logic [9:0]        i_ramp_start_level_param,
    input wire logic [8:0]        i_ramp_time_param,
    input wire logic [9:0]        i_boost_current_level_param,
    input wire logic [6:0]        i_boost_duration_param,
    input wire logic              i_starter_topology_param,
    input wire mss_pkg::mss_ref_s o_ref,
    input wire logic              o_starting,
    input wire logic              o_boosting,
    input wire logic              o_full_voltage,
    input wire logic              o_delta_run,
    input wire logic              o_full_speed_reached,
    input wire logic              o_fault,
    input wire logic [7:0]        o_fault_code
);
    // ==========================================================
    // helpers: cycles since start, effective settings
    logic [31:0] cnt_q;
    logic [31:0] lim;
    logic [31:0] blim;
    logic [9:0]  sl;
    logic        low;
    logic        bon;
    assign low  = ({16'h0, i_motor_current} * 32'd100) < ({16'h0, i_rated_load_current} * 32'd175);
    assign lim  = ((i_accel_time_limit_param inside {[1:900]}) ?
                   i_accel_time_limit_param : 10'd20) * 10 * TICK_CYCLES;
    assign blim = ((i_boost_duration_param inside {[1:100]}) ?
                   i_boost_duration_param : 7'd10) * TICK_CYCLES;
    assign sl   = (i_ramp_start_level_param inside {[1:100]}) ? i_ramp_start_level_param : 10'd25;
    assign bon  = i_boost_current_level_param inside {[100:800]};
    always_ff @(posedge i_mclk) begin
        if (i_reset || !i_start_cmd) begin
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // ==========================================================
    // properties
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    sequence s_rise;
        $rose(i_start_cmd) && !o_starting && !o_fault && !o_full_speed_reached;
    endsequence

    a_fault_code_set: assert property (o_fault |-> o_fault_code == 8'h01)
        else $error("fault code wrong");
    a_code_idle_zero: assert property (!o_fault |-> o_fault_code == 8'h00)
        else $error("fault code without fault");
    a_stop_clears: assert property (!i_start_cmd |=> !o_fault && !o_full_speed_reached)
        else $error("stop did not clear");
    a_speed_no_fault: assert property (o_fault |-> !o_full_speed_reached)
        else $error("fault while up to speed");
    a_uts_expiry: assert property ($rose(o_fault) |-> cnt_q inside {[lim:lim+3]})
        else $error("fault at wrong time");
    a_boost_length: assert property ($fell(o_boosting) && i_start_cmd && !o_fault
        |-> cnt_q inside {[blim:blim+3]})
        else $error("boost length wrong");
    a_boost_first: assert property (s_rise ##0 bon |=> o_boosting
        && o_ref.level == $past(i_boost_current_level_param))
        else $error("boost not applied");
    a_init_level: assert property (s_rise ##0 !bon && i_ramp_profile_select_param != 2'h1
        && i_ramp_time_param inside {[1:300]} |=> o_ref.level == $past(sl))
        else $error("ramp start level wrong");
    a_volt_full: assert property (o_fault && i_ramp_profile_select_param == 2'h0
        |-> o_full_voltage)
        else $error("full voltage missing");
    a_wye_delta: assert property (o_fault && i_starter_topology_param |-> o_delta_run)
        else $error("delta transfer missing");
    a_low_current: assert property ($rose(o_full_speed_reached) |-> $past(low, 2))
        else $error("full speed with high current");
endmodule

bind mss_motor_start_sequencer mss_seq_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.*);

/* File: testbench/mss_motor_model.sv */
// Purpose: motor seen through the power stage
// Assumes: a stalled rotor draws three times rated current
// Notes:   a free rotor settles at half of rated current
`timescale 1ns/1ps

module mss_motor_model (
    input  wire logic        i_mclk,
    input  wire logic        i_stall,
    input  wire logic [15:0] i_rated,
    output logic [15:0]      o_current
);
    // ==========================================================
    // current follows rotor state one cycle late
    always_ff @(posedge i_mclk) begin
        o_current <= i_stall ? i_rated * 16'h3 : i_rated >> 1;
    end
endmodule

/* File: testbench/mss_motor_start_sequencer_tb_top.sv */
// Purpose: self-checking bench of the start sequencer
// Assumes: tick of 10 clocks, so one second is 100 clocks
// Notes:   overload input is held low
`timescale 1ns/1ps

module mss_motor_start_sequencer_tb_top;
    localparam int TK = 10;
    logic              i_mclk = 0;
    logic              i_reset = 1;
    logic              st = 0;
    logic              stall = 0;
    logic              topo = 0;
    logic [15:0]       cur;
    logic [15:0]       rated = 16'h0064;
    logic [9:0]        full_speed_reached = 0;
    logic [9:0]        sl = 10'h028;
    logic [9:0]        bl = 0;
    logic [1:0]        pr = 0;
    logic [8:0]        rt = 0;
    logic [6:0]        bt = 7'h05;
    mss_pkg::mss_ref_s rf;
    logic              sta, bo, fv, dr, fs, flt;
    logic [7:0]        fc;
    int                mismatches = 0;
    int                n_compared = 0;

    always #5 i_mclk = ~i_mclk;

    mss_motor_model u_mss_motor_model (.i_mclk(i_mclk), .i_stall(stall), .i_rated(rated),
        .o_current(cur));
    mss_motor_start_sequencer #(.TICK_CYCLES(TK)) u_mss_motor_start_sequencer (
        .i_mclk(i_mclk), .i_reset(i_reset), .i_start_cmd(st), .i_overload_trip(1'b0),
        .i_motor_current(cur), .i_rated_load_current(rated), .i_accel_time_limit_param(full_speed_reached),
        .i_ramp_profile_select_param(pr), .i_ramp_start_level_param(sl),
        .i_ramp_end_level_param(10'h0c8), .i_init_current_param(10'h096),
        .i_max_current_param(10'h258), .i_ramp_time_param(rt),
        .i_boost_current_level_param(bl), .i_boost_duration_param(bt),
        .i_starter_topology_param(topo), .o_ref(rf), .o_starting(sta), .o_boosting(bo),
        .o_full_voltage(fv), .o_delta_run(dr), .o_full_speed_reached(fs), .o_fault(flt),
        .o_fault_code(fc));

    // ==========================================================
    // shared steps
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic go(input logic [1:0] p, input logic [9:0] b, input logic [8:0] r,
                      input logic [9:0] u, input logic s, input logic t, input logic [9:0] l);
        @(posedge i_mclk);
        pr <= p;
        bl <= b;
        rt <= r;
        full_speed_reached <= u;
        stall <= s;
        topo <= t;
        sl <= l;
        @(posedge i_mclk);
        st <= 1'b1;
        cyc(1);
    endtask
    task automatic stop();
        @(posedge i_mclk);
        st <= 1'b0;
        cyc(2);
        chk("fault after stop", 16'h0, {15'h0, flt});
    endtask

    // ==========================================================
    // scenarios
    // ramp 5 s longer than limit 1 s: every start faults
    task automatic t_stall();
        go(2'h0, 10'h0c8, 9'h005, 10'h001, 1'b1, 1'b1, 10'h028);
        chk("boosting", 16'h1, {15'h0, bo});
        chk("boost level", 16'h00c8, {6'h0, rf.level});
        cyc(5 * TK + 1);
        chk("boost end", 16'h0, {15'h0, bo});
        chk("volt start", 16'h0028, {6'h0, rf.level});
        cyc(44);
        chk("early fault", 16'h0, {15'h0, flt});
        cyc(8);
        chk("fault", 16'h1, {15'h0, flt});
        chk("code", 16'h0001, {8'h0, fc});
        chk("full voltage", 16'h1, {15'h0, fv});
        chk("delta", 16'h1, {15'h0, dr});
        stop();
    endtask
    // limit 2 s above ramp 1 s, no boost: reaches full speed
    task automatic t_run();
        go(2'h1, 10'h000, 9'h001, 10'h002, 1'b0, 1'b0, 10'h028);
        chk("no boost", 16'h0, {15'h0, bo});
        chk("starting", 16'h1, {15'h0, sta});
        chk("curr kind", 16'h1, {14'h0, rf.kind});
        chk("curr start", 16'h0096, {6'h0, rf.level});
        cyc(170);
        chk("full speed", 16'h1, {15'h0, fs});
        chk("hold max", 16'h0258, {6'h0, rf.level});
        chk("no fault", 16'h0, {15'h0, flt});
        stop();
    endtask
    // out-of-range settings fall back to 25 percent and 20 s
    task automatic t_levels();
        for (int p = 2; p < 4; p++) begin
            go(p[1:0], 10'h3ff, 9'h001, 10'h000, 1'b1, 1'b0, 10'h000);
            chk("kind", 16'(p), {14'h0, rf.kind});
            chk("default start", 16'h0019, {6'h0, rf.level});
            chk("bad boost off", 16'h0, {15'h0, bo});
            cyc(1990);
            chk("fault early", 16'h0, {15'h0, flt});
            cyc(20);
            chk("fault default", 16'h1, {15'h0, flt});
            stop();
        end
    endtask

    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #400000;
        mismatches++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge i_mclk);
        i_reset <= 1'b0;
        t_stall();
        t_run();
        t_levels();
        complete_run();
    end
endmodule
